// *** include/btc_pkg.sv ***
package btc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_MAIN = 8'h0D;
	localparam logic [7:0] ADDR_MODE = 8'h0E;
	localparam logic [7:0] ADDR_STBY = 8'h0F;
	localparam logic [7:0] MASK_MAIN = 8'hFF;
	localparam logic [7:0] MASK_MODE = 8'h67;
	localparam logic [7:0] MASK_STBY = 8'h1F;
	localparam logic [7:0] RST_MAIN = 8'h1D;
	localparam logic [7:0] RST_MODE = 8'h06;
	localparam logic [7:0] RST_STBY = 8'h1D;
	localparam int MAIN_ON_BIT = 7;
	localparam int MAIN_RIPPLE_BIT = 6;
	localparam int MAIN_PWM_BIT = 5;
	localparam int MODE_STBY_BIT = 6;
	localparam int MODE_DISCH_BIT = 5;
	localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
	localparam logic [4:0] VCODE_ALIAS = 5'h1F;
	// value arbitrary
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int STEP_UV = 80000;
	localparam int RATE_UVUS_0 = 480;
	localparam int RATE_UVUS_1 = 96;
	localparam int RATE_UVUS_2 = 1920;
	localparam int RATE_UVUS_3 = 3840;
	localparam int RATE_UVUS_4 = 7680;
	localparam int RATE_UVUS_5 = 15360;
	localparam int RATE_UVUS_6 = 30720;
	localparam int STEP_CYC_0 = STEP_UV * 1000 / (RATE_UVUS_0 * CLK_PERIOD_NS);
	localparam int STEP_CYC_1 = STEP_UV * 1000 / (RATE_UVUS_1 * CLK_PERIOD_NS);
	localparam int STEP_CYC_2 = STEP_UV * 1000 / (RATE_UVUS_2 * CLK_PERIOD_NS);
	localparam int STEP_CYC_3 = STEP_UV * 1000 / (RATE_UVUS_3 * CLK_PERIOD_NS);
	localparam int STEP_CYC_4 = STEP_UV * 1000 / (RATE_UVUS_4 * CLK_PERIOD_NS);
	localparam int STEP_CYC_5 = STEP_UV * 1000 / (RATE_UVUS_5 * CLK_PERIOD_NS);
	localparam int STEP_CYC_6 = STEP_UV * 1000 / (RATE_UVUS_6 * CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] main;
		logic [7:0] mode;
		logic [7:0] stby;
	} btc_regs_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} btc_bus_ev_t;

	// top code aliases the bottom one, so order by level
	function automatic logic [4:0] btcLevel(input logic [4:0] code);
		btcLevel = (code == VCODE_ALIAS) ? 5'h00 : code;
	endfunction : btcLevel

endpackage : btc_pkg

// *** logic/btc_slew.sv ***
module btc_slew #(
	parameter int CNT_W = 18,
	parameter int CYC_0 = 41666,
	parameter int CYC_1 = 208333,
	parameter int CYC_2 = 10416,
	parameter int CYC_3 = 5208,
	parameter int CYC_4 = 2604,
	parameter int CYC_5 = 1302,
	parameter int CYC_6 = 651
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// settings
	input wire logic [4:0] targetCode,
	input wire logic [2:0] slewCode,
	// ramp
	output logic [4:0] rampCode
);
	import btc_pkg::*;

	logic [4:0] cur_q, cur_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] limit;

	always_comb begin
		case (slewCode)
			3'h0: limit = CNT_W'(CYC_0);
			3'h1: limit = CNT_W'(CYC_1);
			3'h2: limit = CNT_W'(CYC_2);
			3'h3: limit = CNT_W'(CYC_3);
			3'h4: limit = CNT_W'(CYC_4);
			3'h5: limit = CNT_W'(CYC_5);
			3'h6: limit = CNT_W'(CYC_6);
			default: limit = CNT_W'(1);
		endcase
	end

	// one code step is 80 mV; step period follows the slew setting
	always_comb begin
		cur_d = cur_q;
		cnt_d = '0;
		if (btcLevel(cur_q) == btcLevel(targetCode)) begin
			cur_d = targetCode;
		end else if (slewCode == SLEW_IMMEDIATE) begin
			cur_d = targetCode;
		end else if (cnt_q >= limit - CNT_W'(1)) begin
			if (btcLevel(cur_q) < btcLevel(targetCode)) begin
				cur_d = (cur_q == VCODE_ALIAS) ? 5'h01 : cur_q + 5'h01;
			end else begin
				cur_d = cur_q - 5'h01;
			end
		end else begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_q <= RST_MAIN[4:0];
			cnt_q <= '0;
		end else begin
			cur_q <= cur_d;
			cnt_q <= cnt_d;
		end
	end

	assign rampCode = cur_q;

endmodule : btc_slew

// *** logic/btc_regs.sv ***
module btc_regs #(
	parameter logic [6:0] DEV_ADDR = btc_pkg::DEV_ADDR_DEFAULT,
	parameter int STEP_CYC_0 = btc_pkg::STEP_CYC_0,
	parameter int STEP_CYC_1 = btc_pkg::STEP_CYC_1,
	parameter int STEP_CYC_2 = btc_pkg::STEP_CYC_2,
	parameter int STEP_CYC_3 = btc_pkg::STEP_CYC_3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial host pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// converter controls
	output logic buckTwoOn,
	output logic rippleSelect,
	output logic forcePwmOnly,
	output logic standbySelect,
	output logic dischargeEnable,
	output logic [2:0] slewCode,
	output logic [4:0] targetCode,
	output logic [4:0] rampCode
);
	import btc_pkg::*;

	// ------------------------------------------------------------
	// register access helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] readReg(input logic [7:0] a,
		input btc_regs_t r);
		case (a)
			ADDR_MAIN: readReg = r.main;
			ADDR_MODE: readReg = r.mode;
			ADDR_STBY: readReg = r.stby;
			default: readReg = 8'h00;
		endcase
	endfunction : readReg

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_ACKA = 9'h004,
		S_PTR = 9'h008,
		S_ACKP = 9'h010,
		S_WDAT = 9'h020,
		S_ACKW = 9'h040,
		S_RDAT = 9'h080,
		S_ACKR = 9'h100
	} btc_state_t;

	// ------------------------------------------------------------
	// pin synchronisers and glitch filter
	// ------------------------------------------------------------
	logic [2:0] sclSync_q, sclSync_d, sdaSync_q, sdaSync_d;
	logic sclF_q, sclF_d, sdaF_q, sdaF_d, sclP_q, sdaP_q;
	btc_bus_ev_t ev;

	always_comb begin
		sclSync_d = {sclSync_q[1:0], sclIn};
		sdaSync_d = {sdaSync_q[1:0], sdaIn};
		sclF_d = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclF_q;
		sdaF_d = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaF_q;
		ev.start = sclF_q & sclP_q & sdaP_q & ~sdaF_q;
		ev.stop = sclF_q & sclP_q & ~sdaP_q & sdaF_q;
		ev.rise = sclF_q & ~sclP_q;
		ev.fall = ~sclF_q & sclP_q;
		ev.sda = sdaF_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclSync_q <= 3'h7;
			sdaSync_q <= 3'h7;
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
		end else begin
			sclSync_q <= sclSync_d;
			sdaSync_q <= sdaSync_d;
			sclF_q <= sclF_d;
			sdaF_q <= sdaF_d;
			sclP_q <= sclF_q;
			sdaP_q <= sdaF_q;
		end
	end

	// ------------------------------------------------------------
	// serial protocol engine
	// ------------------------------------------------------------
	btc_state_t st_q, st_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rdByte;
	logic oe_q, oe_d, nack_q, nack_d, wrStb;
	btc_regs_t regs_q, regs_d;

	assign rdByte = readReg(ptr_q, regs_q);

	always_comb begin
		st_d = st_q;
		bitCnt_d = bitCnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		nack_d = nack_q;
		wrStb = 1'b0;
		if (ev.start) begin
			st_d = S_ADDR;
			bitCnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (ev.stop) begin
			st_d = S_IDLE;
			oe_d = 1'b0;
		end else if (ev.rise) begin
			case (st_q)
				S_ADDR, S_PTR, S_WDAT: begin
					sh_d = {sh_q[6:0], ev.sda};
					bitCnt_d = bitCnt_q + 4'h1;
				end
				S_RDAT: begin
					sh_d = {sh_q[6:0], 1'b0};
					bitCnt_d = bitCnt_q + 4'h1;
				end
				S_ACKR: nack_d = ev.sda;
				default: ;
			endcase
		end else if (ev.fall) begin
			case (st_q)
				S_ADDR: begin
					if (bitCnt_q == 4'h8) begin
						if (sh_q[7:1] == DEV_ADDR) begin
							st_d = S_ACKA;
							oe_d = 1'b1;
						end else begin
							st_d = S_IDLE;
						end
					end
				end
				S_ACKA: begin
					bitCnt_d = 4'h0;
					if (sh_q[0]) begin
						st_d = S_RDAT;
						sh_d = rdByte;
						oe_d = ~rdByte[7];
					end else begin
						st_d = S_PTR;
						oe_d = 1'b0;
					end
				end
				S_PTR: begin
					if (bitCnt_q == 4'h8) begin
						ptr_d = sh_q;
						st_d = S_ACKP;
						oe_d = 1'b1;
					end
				end
				S_WDAT: begin
					if (bitCnt_q == 4'h8) begin
						wrStb = 1'b1;
						ptr_d = ptr_q + 8'h01;
						st_d = S_ACKW;
						oe_d = 1'b1;
					end
				end
				S_ACKP, S_ACKW: begin
					st_d = S_WDAT;
					bitCnt_d = 4'h0;
					oe_d = 1'b0;
				end
				S_RDAT: begin
					if (bitCnt_q == 4'h8) begin
						st_d = S_ACKR;
						ptr_d = ptr_q + 8'h01;
						oe_d = 1'b0;
					end else begin
						oe_d = ~sh_q[7];
					end
				end
				S_ACKR: begin
					bitCnt_d = 4'h0;
					if (nack_q) begin
						st_d = S_IDLE;
					end else begin
						st_d = S_RDAT;
						sh_d = rdByte;
						oe_d = ~rdByte[7];
					end
				end
				default: st_d = S_IDLE;
			endcase
		end
	end

	// open drain: the pin is only ever pulled low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			bitCnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			nack_q <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			st_q <= st_d;
			bitCnt_q <= bitCnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			nack_q <= nack_d;
			sdaOut <= 1'b0;
		end
	end

	assign sdaOe = oe_q;

	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------
	logic [4:0] target_q, target_d;

	always_comb begin
		regs_d = regs_q;
		if (wrStb) begin
			case (ptr_q)
				ADDR_MAIN: regs_d.main = sh_q & MASK_MAIN;
				ADDR_MODE: regs_d.mode = sh_q & MASK_MODE;
				ADDR_STBY: regs_d.stby = sh_q & MASK_STBY;
				default: ;
			endcase
		end
		// standby picks which field the converter follows
		target_d = regs_q.mode[MODE_STBY_BIT] ? regs_q.stby[4:0] :
			regs_q.main[4:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regs_q.main <= RST_MAIN;
			regs_q.mode <= RST_MODE;
			regs_q.stby <= RST_STBY;
			target_q <= RST_MAIN[4:0];
		end else begin
			regs_q <= regs_d;
			target_q <= target_d;
		end
	end

	assign buckTwoOn = regs_q.main[MAIN_ON_BIT];
	assign rippleSelect = regs_q.main[MAIN_RIPPLE_BIT];
	assign forcePwmOnly = regs_q.main[MAIN_PWM_BIT];
	assign standbySelect = regs_q.mode[MODE_STBY_BIT];
	assign dischargeEnable = regs_q.mode[MODE_DISCH_BIT];
	assign slewCode = regs_q.mode[2:0];
	assign targetCode = target_q;

	// ------------------------------------------------------------
	// output voltage ramp
	// ------------------------------------------------------------
	btc_slew #(
		.CNT_W(18),
		.CYC_0(STEP_CYC_0),
		.CYC_1(STEP_CYC_1),
		.CYC_2(STEP_CYC_2),
		.CYC_3(STEP_CYC_3),
		.CYC_4(btc_pkg::STEP_CYC_4),
		.CYC_5(btc_pkg::STEP_CYC_5),
		.CYC_6(btc_pkg::STEP_CYC_6)
	) uSlew (
		.clk(clk),
		.rst(rst),
		.targetCode(target_q),
		.slewCode(regs_q.mode[2:0]),
		.rampCode(rampCode)
	);

endmodule : btc_regs

// *** verif/btc_regs_assertions.sv ***
module btc_regs_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial host pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// converter controls
	input wire logic buckTwoOn,
	input wire logic rippleSelect,
	input wire logic forcePwmOnly,
	input wire logic standbySelect,
	input wire logic dischargeEnable,
	input wire logic [2:0] slewCode,
	input wire logic [4:0] targetCode,
	input wire logic [4:0] rampCode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// top code sits at the bottom level
	function automatic int lv(input logic [4:0] c);
		return (c == 5'h1F) ? 0 : int'(c);
	endfunction : lv

	function automatic int gap(input logic [4:0] a, input logic [4:0] b);
		return (lv(a) > lv(b)) ? lv(a) - lv(b) : lv(b) - lv(a);
	endfunction : gap

	sequence rampStep;
		$changed(rampCode) && lv(rampCode) != lv($past(rampCode))
		&& slewCode != 3'h7 && $stable(slewCode);
	endsequence

	AST_RST_VALS: assert property ($fell(rst) |->
		targetCode == 5'h1D && rampCode == 5'h1D && slewCode == 3'h6
		&& !buckTwoOn && !standbySelect && !dischargeEnable)
		else $error("reset values wrong");
	// writes only commit while the bus clock is low
	AST_CTRL_QUIET: assert property (sclIn [*8] |->
		$stable({buckTwoOn, rippleSelect, forcePwmOnly, standbySelect,
		dischargeEnable, slewCode, targetCode}))
		else $error("control moved while bus clock high");
	AST_RAMP_IMM: assert property (
		slewCode == 3'h7 && $changed(targetCode) |=>
		rampCode == $past(targetCode))
		else $error("immediate slew did not jump");
	AST_RAMP_ONE: assert property (
		rampStep |-> gap(rampCode, $past(rampCode)) == 1)
		else $error("ramp moved more than one code");
	AST_RAMP_TOWARD: assert property (
		rampStep and $stable(targetCode) |->
		gap(targetCode, rampCode) < gap(targetCode, $past(rampCode)))
		else $error("ramp moved away from target");
	AST_RAMP_HOLD: assert property (rampStep |=>
		(slewCode == 3'h7 || $stable(rampCode)) [*8])
		else $error("ramp steps too close");
	AST_OE_EDGE: assert property ($changed(sdaOe) |->
		!sclIn && !$past(sclIn, 3))
		else $error("data line changed outside clock low");
	AST_OUT_ZERO: assert property (sdaOut == 1'b0)
		else $error("data output not low");
endmodule : btc_regs_assertions

bind btc_regs btc_regs_assertions chk (.clk(clk), .rst(rst),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.buckTwoOn(buckTwoOn), .rippleSelect(rippleSelect),
	.forcePwmOnly(forcePwmOnly), .standbySelect(standbySelect),
	.dischargeEnable(dischargeEnable), .slewCode(slewCode),
	.targetCode(targetCode), .rampCode(rampCode));

// *** verif/btc_host.sv ***
module btc_host (
	// clock
	input wire logic clk,
	// bus pins
	input wire logic sdaIn,
	output logic scl,
	output logic sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// ten cycles a phase keeps clear of the input filter
	task automatic bitIo(input logic b, output logic r);
		sdaLow = ~b;
		tick(10);
		scl = 1'b1;
		tick(5);
		r = sdaIn;
		tick(5);
		scl = 1'b0;
		tick(10);
	endtask : bitIo

	task automatic start();
		sdaLow = 1'b0;
		tick(10);
		scl = 1'b1;
		tick(10);
		sdaLow = 1'b1;
		tick(10);
		scl = 1'b0;
		tick(10);
	endtask : start

	task automatic stop();
		sdaLow = 1'b1;
		tick(10);
		scl = 1'b1;
		tick(10);
		sdaLow = 1'b0;
		tick(10);
	endtask : stop

	task automatic xfer(input logic [7:0] d, input logic nack,
		output logic [7:0] r, output logic acked);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitIo(d[i], r[i]);
		end
		bitIo(nack, a);
		acked = ~a;
	endtask : xfer
endmodule : btc_host

// *** verif/buck_two_control_regs_tb_top.sv ***
module buck_two_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import btc_pkg::*;
	localparam logic [7:0] DA = {DEV_ADDR_DEFAULT, 1'b0};
	logic clk, rst, scl, hostLow, sdaOut, sdaOe, sdaWire;
	logic buckTwoOn, rippleSelect, forcePwmOnly, standbySelect;
	logic dischargeEnable;
	logic [2:0] slewCode;
	logic [4:0] targetCode, rampCode;
	int errorCnt = 0;
	int nTests = 0;

	// pull-up on the data line
	assign sdaWire = ~(hostLow | sdaOe);

	btc_regs #(.STEP_CYC_0(80), .STEP_CYC_1(400), .STEP_CYC_2(20),
		.STEP_CYC_3(10)) uut (.clk(clk), .rst(rst), .sclIn(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.buckTwoOn(buckTwoOn), .rippleSelect(rippleSelect),
		.forcePwmOnly(forcePwmOnly), .standbySelect(standbySelect),
		.dischargeEnable(dischargeEnable), .slewCode(slewCode),
		.targetCode(targetCode), .rampCode(rampCode));
	btc_host host (.clk(clk), .sdaIn(sdaWire), .scl(scl), .sdaLow(hostLow));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : giveVerdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic k1, k2, k3;
		host.start();
		host.xfer(DA, 1'b1, r, k1);
		host.xfer(a, 1'b1, r, k2);
		host.xfer(d, 1'b1, r, k3);
		host.stop();
		check({5'h0, k1, k2, k3}, 8'h07);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r, v;
		logic k;
		host.start();
		host.xfer(DA, 1'b1, r, k);
		host.xfer(a, 1'b1, r, k);
		host.start();
		host.xfer(DA | 8'h01, 1'b1, r, k);
		host.xfer(8'hFF, 1'b1, v, k);
		host.stop();
		check(v, e);
	endtask : rchk

	task automatic testReset();
		rchk(ADDR_MAIN, 8'h1D);
		rchk(ADDR_MODE, 8'h06);
		rchk(ADDR_STBY, 8'h1D);
		check({7'h0, buckTwoOn}, 8'h00);
		$display("reset test done");
	endtask : testReset

	task automatic testMain();
		logic [7:0] v[2] = '{8'hE5, 8'h1A};
		foreach (v[i]) begin
			wr(ADDR_MAIN, v[i]);
			rchk(ADDR_MAIN, v[i]);
			check({5'h0, buckTwoOn, rippleSelect, forcePwmOnly},
				8'(v[i][7:5]));
			check(8'(targetCode), 8'(v[i][4:0]));
		end
		$display("main control test done");
	endtask : testMain

	task automatic testMode();
		wr(ADDR_MODE, 8'hFF);
		rchk(ADDR_MODE, 8'h67);
		check({3'h0, standbySelect, dischargeEnable, slewCode}, 8'h1F);
		wr(ADDR_STBY, 8'hFF);
		rchk(ADDR_STBY, 8'h1F);
		wr(ADDR_MODE, 8'h18);
		rchk(ADDR_MODE, 8'h00);
		check({3'h0, standbySelect, dischargeEnable, slewCode}, 8'h00);
		$display("mode test done");
	endtask : testMode

	task automatic testStandby();
		wr(ADDR_MODE, 8'h07);
		wr(ADDR_MAIN, 8'h05);
		wr(ADDR_STBY, 8'h0A);
		check(8'(rampCode), 8'h05);
		wr(ADDR_MODE, 8'h47);
		check(8'(targetCode), 8'h0A);
		check(8'(rampCode), 8'h0A);
		wr(ADDR_MODE, 8'h07);
		check(8'(rampCode), 8'h05);
		$display("standby test done");
	endtask : testStandby

	// bus time eats up to 80 cycles of the wait; fast codes take more steps
	task automatic testSlew();
		int cyc[7] = '{80, 400, 20, 10, STEP_CYC_4, STEP_CYC_5, STEP_CYC_6};
		logic [4:0] tgt;
		int n;
		int k;
		logic inWin;
		for (int i = 0; i < 7; i++) begin
			k = (cyc[i] < 80) ? 12 : 3;
			tgt = (i % 2 == 0) ? 5'(5 + k) : 5'h05;
			wr(ADDR_MODE, 8'(i));
			wr(ADDR_MAIN, {3'h0, tgt});
			n = 0;
			while (rampCode !== tgt && n < 2 * k * cyc[i] + 200) begin
				@(negedge clk);
				n++;
			end
			inWin = (n > k * cyc[i] - 80) && (n <= k * cyc[i]);
			check({7'h0, inWin}, 8'h01);
			if (rampCode !== tgt)
				break;
		end
		$display("slew test done");
	endtask : testSlew

	task automatic testRefused();
		logic [7:0] r;
		logic [7:0] b0;
		logic [7:0] b1;
		logic k;
		host.start();
		host.xfer(DA ^ 8'h02, 1'b1, r, k);
		host.stop();
		check({7'h0, k}, 8'h00);
		wr(8'h10, 8'hFF);
		rchk(8'h10, 8'h00);
		rchk(ADDR_MAIN, 8'h08);
		// master ack carries the read on to the next register
		host.start();
		host.xfer(DA, 1'b1, r, k);
		host.xfer(ADDR_MAIN, 1'b1, r, k);
		host.start();
		host.xfer(DA | 8'h01, 1'b1, r, k);
		host.xfer(8'hFF, 1'b0, b0, k);
		host.xfer(8'hFF, 1'b1, b1, k);
		host.stop();
		check(b0, 8'h08);
		check(b1, 8'h06);
		$display("refusal test done");
	endtask : testRefused

	initial begin
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		testReset();
		testMain();
		testMode();
		testStandby();
		testSlew();
		testRefused();
		giveVerdict();
	end
endmodule : buck_two_control_regs_tb_top
